/* File: src/ahrp_params.svh */
// constants for the array host register port
`ifndef AHRP_PARAMS_SVH
`define AHRP_PARAMS_SVH
// ===========================================
// register area offsets (low nibble of host byte offset)
`define CTRL_OFS      4'h0
`define SHIFT_OFS     4'h2
`define XFER_OFS      4'h4
`define IO_AREA_BYTES 32'd16
`define MEM_BYTES_DEF 32'h00020000
// ===========================================
// control word bit positions
`define B_RUN     15
`define B_IRQ_EN  14
`define B_FLAG    13
`define B_SPARE   12
`define B_MIRQ    11
`define B_RESET   10
`define B_STEP    9
`define B_PEND    8
// ===========================================
// chain layout and timing
`define CHAIN_W   128
`define WORD_W    16
`define MCLK_NS   10
`define SHIFT_NS  20*`MCLK_NS
`define SHIFT_CYC ((`SHIFT_NS + `MCLK_NS - 1) / `MCLK_NS)
`endif

/* File: src/ahrp_pkg.sv */
// types for the array host register port
package ahrp_pkg;
	typedef enum logic [2:0] {
		ST_IDLE  = 3'h0,
		ST_MWAIT = 3'h1,
		ST_MACC  = 3'h2,
		ST_SHIFT = 3'h3,
		ST_DONE  = 3'h4
	} host_state_t;
endpackage : ahrp_pkg

/* File: src/array_host_register_port.sv */
// host register port of the array board: memory window, control word, scan chain
`timescale 1ns/10ps
`default_nettype none
`include "ahrp_params.svh"
module array_host_register_port #(
	parameter logic [31:0] MEM_BYTES = `MEM_BYTES_DEF
) (
	input  wire logic          mclk,
	input  wire logic          reset,
	input  wire logic          host_req,
	input  wire logic          host_write,
	input  wire logic [1:0]    host_be,
	input  wire logic [18:0]   host_addr,
	input  wire logic [15:0]   host_wdata,
	input  wire logic          host_iack,
	output var  logic          host_ack,
	output var  logic [15:0]   host_rdata,
	output var  logic          host_irq,
	output var  logic          mem_req,
	output var  logic          mem_we,
	output var  logic [1:0]    mem_be,
	output var  logic [19:0]   mem_addr,
	output var  logic [15:0]   mem_wdata,
	input  wire logic [15:0]   mem_rdata,
	input  wire logic          mem_ack,
	input  wire logic          seq_irq_request,
	input  wire logic          arr_micro_irq_clear,
	input  wire logic          arr_par_load,
	input  wire logic [127:0]  arr_par_value,
	output var  logic          uclk,
	output var  logic          array_reset,
	output var  logic          host_sync_flag,
	output var  logic          micro_irq_request,
	output var  logic [15:0]   memory_data_reg,
	output var  logic [15:0]   memory_address_reg,
	output var  logic [7:0]    page_select_reg,
	output var  logic [87:0]   pipeline_reg
);
	localparam logic [18:0] IO_BASE = 19'(MEM_BYTES - `IO_AREA_BYTES);
	localparam int          SHIFT_N = `SHIFT_CYC;
	localparam int          BUS_W   = 40;

	// ============================================
	// host pin synchroniser: every host input passes two flops
	logic [BUS_W-1:0] sync1;
	logic [BUS_W-1:0] sync2;
	always_ff @(posedge mclk) begin
		sync1 <= {host_req, host_iack, host_write, host_be, host_addr, host_wdata};
		sync2 <= sync1;
	end
	logic        s_req;
	logic        s_iack;
	logic        s_write;
	logic [1:0]  s_be;
	logic [18:0] s_addr;
	logic [15:0] s_wdata;
	assign {s_req, s_iack, s_write, s_be, s_addr, s_wdata} = sync2;

	wire       in_io  = (s_addr >= IO_BASE);
	wire [3:0] io_ofs = s_addr[3:0];

	// ============================================
	// state
	ahrp_pkg::host_state_t state;
	ahrp_pkg::host_state_t next_state;
	logic [4:0]   cnt;
	logic [4:0]   next_cnt;
	logic [127:0] chain;                              // serial_scan_chain
	logic [127:0] next_chain;
	logic         run;
	logic         next_run;
	logic         host_irq_enable;
	logic         next_host_irq_enable;
	logic         spare_bit;
	logic         next_spare_bit;
	logic         next_host_sync_flag;
	logic         next_micro_irq_request;
	logic         force_array_reset;
	logic         next_force_array_reset;
	logic         one_cycle_step;
	logic         next_one_cycle_step;
	logic         step_active;
	logic         next_step_active;
	logic         host_irq_pending;
	logic         next_host_irq_pending;
	logic [7:0]   host_irq_vector;
	logic [7:0]   next_host_irq_vector;
	logic         next_host_ack;
	logic [15:0]  next_host_rdata;
	logic         next_host_irq;
	logic         next_mem_req;
	logic         next_mem_we;
	logic [1:0]   next_mem_be;
	logic [19:0]  next_mem_addr;
	logic [15:0]  next_mem_wdata;
	logic         next_uclk;
	logic         next_array_reset;
	logic [127:0] par;
	logic [127:0] next_par;

	function automatic logic [15:0] ctrl_word(input logic r, input logic e, input logic f,
		input logic s, input logic m, input logic p, input logic [7:0] v);
		ctrl_word = {r, e, f, s, m, 1'b1, 1'b1, p, v};
	endfunction : ctrl_word

	wire iack_hit  = s_iack && host_irq;
	wire steal     = (state == ahrp_pkg::ST_MWAIT) || (state == ahrp_pkg::ST_MACC);
	wire cycle_go  = (run || one_cycle_step) && !steal;

	always_comb begin
		next_state             = state;
		next_cnt               = cnt;
		next_chain             = chain;
		next_par               = par;
		next_run               = run;
		next_host_irq_enable   = host_irq_enable;
		next_spare_bit         = spare_bit;
		next_host_sync_flag    = host_sync_flag;
		next_micro_irq_request = micro_irq_request;
		next_force_array_reset = force_array_reset;
		next_one_cycle_step    = one_cycle_step;
		next_step_active       = step_active;
		next_host_irq_pending  = host_irq_pending;
		next_host_irq_vector   = host_irq_vector;
		next_host_ack          = host_ack;
		next_host_rdata        = host_rdata;
		next_mem_req           = mem_req;
		next_mem_we            = mem_we;
		next_mem_be            = mem_be;
		next_mem_addr          = mem_addr;
		next_mem_wdata         = mem_wdata;
		next_uclk              = uclk;
		next_array_reset       = array_reset;

		// micro-clock: a cycle is one high and one low mclk; a cleared run
		// still lets a high phase fall, so the present cycle completes
		if (uclk) begin
			next_uclk        = 1'b0;
			next_array_reset = 1'b0;
			if (step_active) begin
				next_one_cycle_step = 1'b0;
				next_step_active    = 1'b0;
			end
		end else if (cycle_go) begin
			next_uclk        = 1'b1;
			next_step_active = !run;
			if (run && force_array_reset) begin
				next_array_reset       = 1'b1;
				next_force_array_reset = 1'b0;
			end
		end

		if (arr_micro_irq_clear)
			next_micro_irq_request = 1'b0;
		if (arr_par_load)
			next_par = arr_par_value;

		case (state)
			ahrp_pkg::ST_IDLE: begin
				if (iack_hit) begin
					next_host_rdata       = {8'h00, host_irq_vector};
					next_host_irq_pending = 1'b0;
					next_host_ack         = 1'b1;
					next_state            = ahrp_pkg::ST_DONE;
				end else if (s_req && !in_io) begin
					next_mem_we    = s_write;
					next_mem_be    = s_be;
					next_mem_addr  = {s_addr[18:1], 2'b00};
					next_mem_wdata = s_wdata;
					next_state     = ahrp_pkg::ST_MWAIT;
				end else if (s_req) begin
					next_host_rdata = 16'h0000;
					next_host_ack   = 1'b1;
					next_state      = ahrp_pkg::ST_DONE;
					case (io_ofs)
						`CTRL_OFS: begin
							if (!s_write) begin
								next_host_rdata = ctrl_word(run, host_irq_enable,
									host_sync_flag, spare_bit, micro_irq_request,
									host_irq_pending, host_irq_vector);
							end else begin
								if (s_be[1]) begin
									next_run             = s_wdata[`B_RUN];
									next_host_irq_enable = s_wdata[`B_IRQ_EN];
									next_host_sync_flag  = s_wdata[`B_FLAG];
									next_spare_bit       = s_wdata[`B_SPARE];
									if (s_wdata[`B_MIRQ])
										next_micro_irq_request = 1'b1;
									else if (!arr_micro_irq_clear)
										next_micro_irq_request = 1'b0;
									if (s_wdata[`B_RESET])
										next_force_array_reset = 1'b1;
									if (s_wdata[`B_STEP])
										next_one_cycle_step = 1'b1;
									if (!s_wdata[`B_IRQ_EN] && !seq_irq_request)
										next_host_irq_pending = 1'b0;
								end
								if (s_be[0])
									next_host_irq_vector = s_wdata[7:0];
							end
						end
						`SHIFT_OFS: begin
							next_host_ack = 1'b0;
							next_cnt      = 5'd0;
							next_state    = ahrp_pkg::ST_SHIFT;
						end
						`XFER_OFS: begin
							if (s_write)
								next_par = chain;
							else
								next_chain = par;
						end
						default: next_host_rdata = 16'h0000;
					endcase
				end
			end
			ahrp_pkg::ST_MWAIT: begin
				// wait for the low phase so the running cycle completes first
				if (!uclk)
					next_mem_req = 1'b1;
				if (mem_req)
					next_state = ahrp_pkg::ST_MACC;
			end
			ahrp_pkg::ST_MACC: begin
				if (mem_ack) begin
					next_mem_req    = 1'b0;
					next_host_rdata = mem_rdata;
					next_host_ack   = 1'b1;
					next_state      = ahrp_pkg::ST_DONE;
				end
			end
			ahrp_pkg::ST_SHIFT: begin
				// one bit per mclk, msb of the word first; idle tail pads to 20
				if (cnt < 5'd16) begin
					next_chain = {chain[126:0],
						s_write ? s_wdata[4'd15 - cnt[3:0]] : 1'b0};
					next_host_rdata = {host_rdata[14:0], chain[127]};
				end
				next_cnt = cnt + 5'd1;
				if (cnt == 5'(SHIFT_N - 1)) begin
					next_host_ack = 1'b1;
					next_state    = ahrp_pkg::ST_DONE;
				end
			end
			ahrp_pkg::ST_DONE: begin
				if (!s_req && !s_iack) begin
					next_host_ack = 1'b0;
					next_state    = ahrp_pkg::ST_IDLE;
				end
			end
			default: next_state = ahrp_pkg::ST_IDLE;
		endcase

		if (seq_irq_request)
			next_host_irq_pending = 1'b1;
		next_host_irq = next_host_irq_pending && next_host_irq_enable;
	end

	// only the system reset clears the control bits; array_reset leaves them
	always_ff @(posedge mclk) begin
		if (reset) begin
			state             <= ahrp_pkg::ST_IDLE;
			cnt               <= 5'd0;
			chain             <= 128'h0;
			par               <= 128'h0;
			run               <= 1'b0;
			host_irq_enable   <= 1'b0;
			host_sync_flag    <= 1'b0;
			spare_bit         <= 1'b0;
			micro_irq_request <= 1'b0;
			force_array_reset <= 1'b0;
			one_cycle_step    <= 1'b0;
			step_active       <= 1'b0;
			host_irq_pending  <= 1'b0;
			host_irq_vector   <= 8'h00;
			host_ack          <= 1'b0;
			host_rdata        <= 16'h0000;
			host_irq          <= 1'b0;
			mem_req           <= 1'b0;
			mem_we            <= 1'b0;
			mem_be            <= 2'b00;
			mem_addr          <= 20'h00000;
			mem_wdata         <= 16'h0000;
			uclk              <= 1'b0;
			array_reset       <= 1'b0;
		end else begin
			state             <= next_state;
			cnt               <= next_cnt;
			chain             <= next_chain;
			par               <= next_par;
			run               <= next_run;
			host_irq_enable   <= next_host_irq_enable;
			host_sync_flag    <= next_host_sync_flag;
			spare_bit         <= next_spare_bit;
			micro_irq_request <= next_micro_irq_request;
			force_array_reset <= next_force_array_reset;
			one_cycle_step    <= next_one_cycle_step;
			step_active       <= next_step_active;
			host_irq_pending  <= next_host_irq_pending;
			host_irq_vector   <= next_host_irq_vector;
			host_ack          <= next_host_ack;
			host_rdata        <= next_host_rdata;
			host_irq          <= next_host_irq;
			mem_req           <= next_mem_req;
			mem_we            <= next_mem_we;
			mem_be            <= next_mem_be;
			mem_addr          <= next_mem_addr;
			mem_wdata         <= next_mem_wdata;
			uclk              <= next_uclk;
			array_reset       <= next_array_reset;
		end
	end

	// chain order: data reg at the top, pipeline at the bottom
	assign {memory_data_reg, memory_address_reg, page_select_reg, pipeline_reg} = par;

	// ============================================
	// assertions
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);

	AST_MEM_ADDR: assert property (mem_req |-> mem_addr == {s_addr[18:1], 2'b00})
		else $error("memory address not twice the host offset");
	AST_NO_IO_MEM: assert property (mem_req |-> !in_io)
		else $error("register area access reached memory");
	AST_CTRL_READ: assert property ((state == ahrp_pkg::ST_IDLE && !iack_hit && s_req && in_io
		&& io_ofs == `CTRL_OFS && !s_write) |=> host_ack && host_rdata[10:9] == 2'b11
		&& host_rdata[8] == $past(host_irq_pending))
		else $error("control read bits 10..8 wrong");
	AST_IRQ_GATE: assert property (host_irq |-> $past(host_irq_enable) || host_irq_enable)
		else $error("host interrupt raised while disabled");
	AST_EN_CLR: assert property ((host_irq_enable && !next_host_irq_enable
		&& !seq_irq_request) |=> !host_irq_pending && !host_irq)
		else $error("pending not cleared with enable");
	AST_PEND_SET: assert property (seq_irq_request |=> host_irq_pending)
		else $error("sequencer request lost");
	AST_STEP_CLR: assert property ((step_active && uclk) |=> !uclk && !one_cycle_step)
		else $error("step bit not cleared at clock fall");
	AST_RESET_START: assert property ($rose(array_reset) |-> uclk && !force_array_reset
		&& $past(run))
		else $error("array reset cycle badly started");
	AST_SHIFT_TIME: assert property ((state == ahrp_pkg::ST_SHIFT && cnt == 5'd0)
		|-> ##20 host_ack)
		else $error("shift port ack not after 20 cycles");
	AST_SHIFT_QUIET: assert property (state == ahrp_pkg::ST_SHIFT |-> !host_ack)
		else $error("shift port acked before the shift finished");
	AST_HALT: assert property ((!run && !one_cycle_step && !uclk) |=> !uclk)
		else $error("micro-clock ran while halted");
	AST_STEAL: assert property ($rose(mem_req) |-> !uclk ##1 !uclk)
		else $error("memory access overlapped an array cycle");

	COV_SHIFT: cover property (state == ahrp_pkg::ST_SHIFT ##20 host_ack);
	COV_MEM: cover property ($rose(mem_req) ##[1:8] mem_ack);
	COV_IACK: cover property (iack_hit && state == ahrp_pkg::ST_IDLE);
	COV_STEP: cover property ($fell(one_cycle_step));
endmodule : array_host_register_port
`default_nettype wire

/* File: test/ahrp_mem_model.sv */
// data memory model answering the port's memory requests
`timescale 1ns/10ps
`default_nettype none
module ahrp_mem_model (
	input  wire logic        mclk,
	input  wire logic        reset,
	input  wire logic        slow,
	input  wire logic        mem_req,
	input  wire logic        mem_we,
	input  wire logic [1:0]  mem_be,
	input  wire logic [19:0] mem_addr,
	input  wire logic [15:0] mem_wdata,
	output var  logic [15:0] mem_rdata,
	output var  logic        mem_ack
);
	logic [15:0] mem [0:255];
	logic [19:0] last_addr;
	logic        done;
	int          wait_cnt;
	int          n_acc;
	initial begin
		for (int i = 0; i < 256; i++) mem[i] = 16'h0000;
	end
	// =============================================
	// one ack pulse per request, prompt or after four waits
	always @(posedge mclk) begin
		mem_ack <= 1'b0;
		mem_rdata <= ~mem_rdata; // read data never lingers between answers
		if (reset) begin
			done <= 1'b0;
			wait_cnt <= 0;
			n_acc <= 0;
			mem_rdata <= 16'h0000;
		end else if (!mem_req) begin
			done <= 1'b0;
			wait_cnt <= 0;
		end else if (!done && wait_cnt < (slow ? 4 : 0)) begin
			wait_cnt <= wait_cnt + 1;
		end else if (!done) begin
			done <= 1'b1;
			mem_ack <= 1'b1;
			last_addr <= mem_addr;
			n_acc <= n_acc + 1;
			if (!mem_we) mem_rdata <= mem[mem_addr[9:2]];
			if (mem_we && mem_be[1]) mem[mem_addr[9:2]][15:8] <= mem_wdata[15:8];
			if (mem_we && mem_be[0]) mem[mem_addr[9:2]][7:0] <= mem_wdata[7:0];
		end
	end
endmodule : ahrp_mem_model
`default_nettype wire

/* File: test/test_array_host_register_port.sv */
// self-checking bench for the array host register port
`timescale 1ns/10ps
`default_nettype none
`include "ahrp_params.svh"
module test_array_host_register_port;
	localparam logic [31:0] MB  = `MEM_BYTES_DEF;
	localparam logic [18:0] IOB = MB[18:0] - 19'h10;
	logic mclk, reset, host_req, host_write, host_iack, slow, host_ack, host_irq;
	logic mem_req, mem_we, mem_ack, uclk, array_reset, host_sync_flag, micro_irq_request;
	logic run, en, flag, spare, mirq, pend, uclk_q, ar_q;
	logic [2:0]   pls;
	logic [1:0]   host_be, mem_be, be;
	logic [18:0]  host_addr, a;
	logic [19:0]  mem_addr;
	logic [15:0]  host_wdata, host_rdata, mem_wdata, mem_rdata, q, d;
	logic [15:0]  memory_data_reg, memory_address_reg;
	logic [15:0]  sh [0:255];
	logic [7:0]   page_select_reg, vec;
	logic [87:0]  pipeline_reg;
	logic [127:0] chain, pv;
	int           bad_count, compares, seed, lat, keep, rises, rst_rises, cycles;

	array_host_register_port #(.MEM_BYTES(MB)) i_array_host_register_port (
		.mclk(mclk), .reset(reset), .host_req(host_req), .host_write(host_write),
		.host_be(host_be), .host_addr(host_addr), .host_wdata(host_wdata), .host_iack(host_iack),
		.host_ack(host_ack), .host_rdata(host_rdata), .host_irq(host_irq), .mem_req(mem_req),
		.mem_we(mem_we), .mem_be(mem_be), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
		.mem_rdata(mem_rdata), .mem_ack(mem_ack), .seq_irq_request(pls[0]),
		.arr_micro_irq_clear(pls[1]), .arr_par_load(pls[2]), .arr_par_value(pv),
		.uclk(uclk), .array_reset(array_reset), .host_sync_flag(host_sync_flag),
		.micro_irq_request(micro_irq_request), .memory_data_reg(memory_data_reg),
		.memory_address_reg(memory_address_reg), .page_select_reg(page_select_reg),
		.pipeline_reg(pipeline_reg));
	ahrp_mem_model i_mem (
		.mclk(mclk), .reset(reset), .slow(slow), .mem_req(mem_req), .mem_we(mem_we),
		.mem_be(mem_be), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
		.mem_ack(mem_ack));

	// =============================================
	// clock, watchdog and micro-clock edge counters
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cycles++;
		uclk_q <= uclk;
		ar_q <= array_reset;
		if (uclk === 1'b1 && uclk_q === 1'b0) rises++;
		if (array_reset === 1'b1 && ar_q === 1'b0) rst_rises++;
		if (cycles == 20000) begin
			bad_count++;
			finish_test();
		end
	end

	// =============================================
	// checking and bus tasks
	task automatic finish_test();
		$display("compares=%0d bad_count=%0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : finish_test
	task automatic chk(input logic [127:0] got, input logic [127:0] exp);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// request held until ack, released, then ack must drop before the next one
	task automatic bus(input logic w, input logic ia, input logic [18:0] ad,
			input logic [1:0] bl, input logic [15:0] wd);
		int n;
		@(negedge mclk);
		host_write = w;
		host_addr = ad;
		host_be = bl;
		host_wdata = wd;
		host_req = !ia;
		host_iack = ia;
		n = 0;
		while (host_ack !== 1'b1 && n < 200) begin
			@(negedge mclk);
			n++;
		end
		q = host_rdata;
		lat = n;
		host_req = 1'b0;
		host_iack = 1'b0;
		host_wdata = ~wd;
		while (host_ack !== 1'b0 && n < 400) begin
			@(negedge mclk);
			n++;
		end
		if (n >= 200) chk(1'b1, 1'b0);
	endtask : bus
	task automatic pulse(input logic [2:0] m);
		@(negedge mclk);
		pls = m;
		@(negedge mclk);
		pls = 3'h0;
	endtask : pulse
	function automatic logic [15:0] ctrl_exp();
		return {run, en, flag, spare, mirq, 2'b11, pend, vec};
	endfunction : ctrl_exp
	task automatic rctl();
		bus(1'b0, 1'b0, IOB, 2'b11, 16'h0000);
		chk(q, ctrl_exp());
	endtask : rctl
	task automatic wctl(input logic rst, input logic step);
		bus(1'b1, 1'b0, IOB, 2'b11, {run, en, flag, spare, mirq, rst, step, 1'b0, vec});
		if (!en) pend = 1'b0;
		rctl();
		chk({host_sync_flag, micro_irq_request}, {flag, mirq});
	endtask : wctl

	// =============================================
	// main sequence
	initial begin
		seed = 32'hd89df479;
		{bad_count, compares} = '0;
		{reset, host_req, host_write, host_iack, slow, pls} = 8'h80;
		{host_be, host_addr, host_wdata, pv} = '0;
		{run, en, flag, spare, mirq, pend, vec} = '0;
		for (int i = 0; i < 256; i++) sh[i] = 16'h0000;
		repeat (5) @(negedge mclk);
		reset = 1'b0;
		rctl();
		for (int i = 0; i < 16; i++) begin
			a = 19'($random(seed)) & 19'h1fe;
			be = 2'($random(seed));
			d = 16'($random(seed));
			slow = 1'($random(seed));
			if (be == 2'b00) be = 2'b11;
			bus(1'b1, 1'b0, a, be, d);
			chk(i_mem.last_addr, {a, 1'b0});
			if (be[1]) sh[a[8:1]][15:8] = d[15:8];
			if (be[0]) sh[a[8:1]][7:0] = d[7:0];
			bus(1'b0, 1'b0, a, 2'b11, 16'h0000);
			chk(q, sh[a[8:1]]);
		end
		keep = i_mem.n_acc;
		for (int i = 0; i < 4; i++) begin
			{flag, spare, mirq, vec} = 11'($random(seed));
			wctl(1'b0, 1'b0);
		end
		mirq = 1'b1;
		wctl(1'b0, 1'b0);
		pulse(3'b010);
		mirq = 1'b0;
		rctl();
		bus(1'b1, 1'b0, IOB + 19'ha, 2'b11, 16'hffff);
		bus(1'b0, 1'b0, IOB + 19'ha, 2'b11, 16'h0000);
		chk(q, 16'h0000);
		en = 1'b0;
		wctl(1'b0, 1'b0);
		pulse(3'b001);
		pend = 1'b1;
		rctl();
		chk(host_irq, 1'b0);
		en = 1'b1;
		wctl(1'b0, 1'b0);
		chk(host_irq, 1'b1);
		bus(1'b0, 1'b1, IOB, 2'b11, 16'h0000);
		chk(q, {8'h00, vec});
		pend = 1'b0;
		rctl();
		pulse(3'b001);
		pend = 1'b1;
		en = 1'b0;
		wctl(1'b0, 1'b0);
		chk(host_irq, 1'b0);
		chk(i_mem.n_acc, keep);
		// scan chain: load eight words, copy out, then capture and unload
		chain = '0;
		for (int i = 0; i < 8; i++) begin
			d = 16'($random(seed));
			bus(1'b1, 1'b0, IOB + 19'h2, 2'b11, d);
			chk(lat >= 20 && lat <= 30, 1'b1);
			chain = {chain[111:0], d};
		end
		chk({memory_data_reg, memory_address_reg, page_select_reg, pipeline_reg}, 0);
		bus(1'b1, 1'b0, IOB + 19'h4, 2'b11, 16'($random(seed)));
		chk({memory_data_reg, memory_address_reg, page_select_reg, pipeline_reg}, chain);
		pv = {$random(seed), $random(seed), $random(seed), $random(seed)};
		pulse(3'b100);
		bus(1'b0, 1'b0, IOB + 19'h4, 2'b11, 16'h0000);
		for (int i = 0; i < 8; i++) begin
			bus(1'b0, 1'b0, IOB + 19'h2, 2'b11, 16'h0000);
			chk(q, pv[127 - 16 * i -: 16]);
		end
		// clock control: step, run with forced reset, stop
		keep = rises;
		wctl(1'b0, 1'b1);
		repeat (10) @(negedge mclk);
		chk(rises, keep + 1);
		run = 1'b1;
		wctl(1'b1, 1'b0);
		repeat (10) @(negedge mclk);
		chk(rst_rises, 1);
		chk(rises > 3, 1'b1);
		bus(1'b0, 1'b0, a, 2'b11, 16'h0000);
		chk(q, sh[a[8:1]]);
		run = 1'b0;
		wctl(1'b0, 1'b0);
		keep = rises;
		repeat (10) @(negedge mclk);
		chk(rises, keep);
		reset = 1'b1;
		repeat (3) @(negedge mclk);
		reset = 1'b0;
		{run, en, flag, spare, mirq, pend, vec} = '0;
		rctl();
		finish_test();
	end
endmodule : test_array_host_register_port
`default_nettype wire
